// ### src/strap_pkg.sv
// constants, field layout and bus-mode decode for the strap capture block
// assumes a 32-bit axi4-lite register bus and nine active-low strap pins
package strap_pkg;
   localparam int STRAP_W = 9;
   // strap positions on the display-memory address pins
   localparam int LB_BIT   = 0;
   localparam int ISA_BIT  = 1;
   localparam int X2_BIT   = 2;
   localparam int USER_BIT = 3;
   localparam int RSV_BIT  = 4;
   localparam int OSC_BIT  = 5;
   localparam int PINF_BIT = 6;
   localparam int TEST_BIT = 7;
   localparam int LV_BIT   = 8;
   // unstrapped pins are pulled up, so the idle capture is all ones
   localparam logic [STRAP_W-1:0] STRAP_RST = 9'h1FF;
   // register byte offsets
   localparam logic [7:0] STATUS_OFF = 8'h00;
   localparam logic [7:0] EXT1_OFF   = 8'h04;
   localparam logic [7:0] CTRL_OFF   = 8'h08;
   // status fields
   localparam int ST_MODE_LSB = 9;
   localparam int ST_RSVD_BUS = 12;
   localparam int ST_VALID    = 13;
   localparam int ST_RSVD_PIN = 14;
   // extension register 1 field
   localparam int EXT1_USER = 3;
   // control fields
   localparam int CTL_BKL = 0;
   localparam int CTL_ROM = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // reference the board feeds when the external oscillator is chosen
   localparam real REF_FREQ_MHZ = 14.31818;

   typedef enum logic [2:0] {
      BUS_VL, BUS_CPU_2X, BUS_ISA, BUS_PCI, BUS_RESERVED
   } bus_mode_t;

   // local-bus, legacy-bus, double-clock selects in that order
   function automatic bus_mode_t decode_bus(input logic [2:0] sel);
      case (sel)
         3'h7:    decode_bus = BUS_VL;
         3'h6:    decode_bus = BUS_CPU_2X;
         3'h5:    decode_bus = BUS_ISA;
         3'h3:    decode_bus = BUS_PCI;
         default: decode_bus = BUS_RESERVED;
      endcase
   endfunction
endpackage

// ### src/cfg_if.sv
// carrier for captured straps and their decoded settings
// assumes one clock domain; driven by capture and decode modules
`timescale 1ns/1ps
interface cfg_if;
   import strap_pkg::*;
   logic [STRAP_W-1:0] strap;
   logic               captured;
   bus_mode_t          bus_mode;
   logic               clock_2x;
   logic               osc_ext;
   logic               alt_address;
   logic               clock_test;
   logic               low_voltage;
   modport capture (output strap, output captured);
   modport decode  (input strap, output bus_mode, output clock_2x,
                    output osc_ext, output alt_address,
                    output clock_test, output low_voltage);
   modport user    (input strap, input captured, input bus_mode,
                    input clock_2x, input osc_ext, input alt_address,
                    input clock_test, input low_voltage);
endinterface

// ### src/strap_capture.sv
// latches the strap pins on the first clock after reset is released
// assumes straps are steady around the reset release edge
`timescale 1ns/1ps
module strap_capture
   import strap_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [STRAP_W-1:0] strap_pins,
   cfg_if.capture                  cfg
);
   import strap_pkg::*;
   logic               in_reset_q;
   logic [STRAP_W-1:0] strap_q;
   logic               captured_q;

   // capture once at the release; values then stay until the next reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reset_q <= 1'b1;
         strap_q    <= STRAP_RST;
         captured_q <= 1'b0;
      end else if (in_reset_q) begin
         in_reset_q <= 1'b0;
         strap_q    <= strap_pins;
         captured_q <= 1'b1;
      end
   end

   assign cfg.strap    = strap_q;
   assign cfg.captured = captured_q;
endmodule

// ### src/cfg_decode.sv
// turns the captured strap word into named settings
// assumes active-low straps: a low capture selects the option
`timescale 1ns/1ps
module cfg_decode
   import strap_pkg::*;
(
   cfg_if.decode cfg
);
   import strap_pkg::*;
   // bus type from the three bus selects
   assign cfg.bus_mode    = decode_bus({cfg.strap[LB_BIT], cfg.strap[ISA_BIT],
                                        cfg.strap[X2_BIT]});
   assign cfg.clock_2x    = ~cfg.strap[X2_BIT];
   assign cfg.osc_ext     = ~cfg.strap[OSC_BIT];
   assign cfg.alt_address = ~cfg.strap[PINF_BIT];
   assign cfg.clock_test  = ~cfg.strap[TEST_BIT];
   assign cfg.low_voltage = ~cfg.strap[LV_BIT];
endmodule

// ### src/strap_config_top.sv
// strap capture top: axi4-lite registers and shared-pin steering
// assumes a 10 mhz aclk, synchronous active-low reset, board pull-downs
//
// How it works
// - sample nine straps when reset ends
// - unstrapped pins read one via pull-ups
// - decode bus selects: VL, CPU-2x, ISA, PCI
// - one combination gives 32-bit doubled-clock CPU
// - clock-rate strap low means doubled bus clock
// - double-clock mode turns ready-return into CPU reset
// - user strap readable in extension register bit 3
// - osc strap low: external 14.31818 MHz reference
// - pin-function strap picks activity/backlight or address
// - clock-test strap low drives clocks on A24/A25
// - low-voltage strap low flags 3.3V operation
// - ISA mode drives ROM select on A24 unless the clock-test strap is low
// - reset input is active low
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module strap_config_top
   import strap_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // straps on the display-memory address pins
   input  wire logic [STRAP_W-1:0] strap_pins,
   output logic                    strap_pins_oe_q,
   // pin 23 and the shared pins
   input  wire logic               ready_return_n,
   input  wire logic               pixel_clock,
   input  wire logic               memory_clock,
   input  wire logic               pin53_in,
   input  wire logic               pin54_in,
   output logic                    a24_out_q,
   output logic                    a24_oe_q,
   output logic                    a25_out_q,
   output logic                    a25_oe_q,
   output logic                    pin54_out_q,
   output logic                    pin54_oe_q,
   output logic                    activity_input_q,
   output logic [1:0]              high_address_q,
   output logic                    ready_return_q,
   output logic                    cpu_reset_input_q,
   // decoded settings
   output strap_pkg::bus_mode_t    bus_mode_q,
   output logic                    clock_2x_q,
   output logic                    osc_ext_q,
   output logic                    low_voltage_q,
   output logic                    config_valid_q,
   // axi4-lite slave
   input  wire logic [7:0]         s_awaddr,
   input  wire logic               s_awvalid,
   output logic                    s_awready,
   input  wire logic [31:0]        s_wdata,
   input  wire logic [3:0]         s_wstrb,
   input  wire logic               s_wvalid,
   output logic                    s_wready,
   output logic [1:0]              s_bresp,
   output logic                    s_bvalid,
   input  wire logic               s_bready,
   input  wire logic [7:0]         s_araddr,
   input  wire logic               s_arvalid,
   output logic                    s_arready,
   output logic [31:0]             s_rdata,
   output logic [1:0]              s_rresp,
   output logic                    s_rvalid,
   input  wire logic               s_rready
);
   import strap_pkg::*;

   cfg_if cfg ();

   strap_capture u_capture (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .strap_pins (strap_pins),
      .cfg        (cfg.capture)
   );

   cfg_decode u_decode (
      .cfg (cfg.decode)
   );

   // control register and bus bookkeeping
   logic [1:0]  ctrl_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wbyte0_q;
   logic        aw_have_q;
   logic        w_have_q;

   // shared-pin role decisions
   wire is_isa    = (cfg.bus_mode == BUS_ISA);
   wire is_cpu_2x = (cfg.bus_mode == BUS_CPU_2X);
   wire a24_drive = cfg.captured && (cfg.clock_test || is_isa);
   wire a24_level = cfg.clock_test ? pixel_clock
                                   : ~ctrl_q[CTL_ROM];
   wire a25_drive = cfg.captured && cfg.clock_test;
   wire pin54_drv = cfg.captured && !cfg.alt_address;

   // pins stay released during reset so the pull-ups set the default
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_pins_oe_q <= 1'b0;
      end else begin
         strap_pins_oe_q <= cfg.captured;
      end
   end

   // registered pin steering and settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a24_out_q         <= 1'b1;
         a24_oe_q          <= 1'b0;
         a25_out_q         <= 1'b0;
         a25_oe_q          <= 1'b0;
         pin54_out_q       <= 1'b0;
         pin54_oe_q        <= 1'b0;
         activity_input_q  <= 1'b0;
         high_address_q    <= 2'h0;
         ready_return_q    <= 1'b0;
         cpu_reset_input_q <= 1'b0;
         bus_mode_q        <= BUS_VL;
         clock_2x_q        <= 1'b0;
         osc_ext_q         <= 1'b0;
         low_voltage_q     <= 1'b0;
         config_valid_q    <= 1'b0;
      end else begin
         a24_out_q         <= a24_level;
         a24_oe_q          <= a24_drive;
         a25_out_q         <= memory_clock;
         a25_oe_q          <= a25_drive;
         pin54_out_q       <= ctrl_q[CTL_BKL];
         pin54_oe_q        <= pin54_drv;
         activity_input_q  <= pin54_drv & pin53_in;
         high_address_q    <= cfg.alt_address ? {pin54_in, pin53_in}
                                              : 2'h0;
         // pin 23 is one pin with two meanings, never both
         ready_return_q    <= !is_cpu_2x & ~ready_return_n;
         cpu_reset_input_q <= is_cpu_2x & ready_return_n;
         bus_mode_q        <= cfg.bus_mode;
         clock_2x_q        <= cfg.clock_2x;
         osc_ext_q         <= cfg.osc_ext;
         low_voltage_q     <= cfg.low_voltage;
         config_valid_q    <= cfg.captured;
      end
   end

   // register read data
   wire [31:0] status_word = {17'h0,
                              ~cfg.strap[RSV_BIT],
                              cfg.captured,
                              cfg.bus_mode == BUS_RESERVED,
                              cfg.bus_mode,
                              cfg.strap};
   wire [31:0] ext1_word   = {28'h0, cfg.strap[USER_BIT], 3'h0};
   wire [31:0] ctrl_word   = {30'h0, ctrl_q};
   wire rd_status = (s_araddr == STATUS_OFF);
   wire rd_ext1   = (s_araddr == EXT1_OFF);
   wire rd_ctrl   = (s_araddr == CTRL_OFF);
   wire rd_hit    = rd_status | rd_ext1 | rd_ctrl;
   wire [31:0] rd_word = rd_status ? status_word :
                         rd_ext1   ? ext1_word   :
                         rd_ctrl   ? ctrl_word   : 32'h0;

   // write side: address and data taken in either order
   wire aw_take  = s_awvalid && s_awready;
   wire w_take   = s_wvalid && s_wready;
   wire aw_ok    = aw_have_q || aw_take;
   wire w_ok     = w_have_q || w_take;
   wire [7:0] wr_addr = aw_have_q ? awaddr_q : s_awaddr;
   wire [31:0] wr_data = w_have_q ? wdata_q : s_wdata;
   wire wr_byte0 = w_have_q ? wbyte0_q : s_wstrb[0];
   wire wr_fire  = aw_ok && w_ok && !s_bvalid;
   wire wr_known = (wr_addr == STATUS_OFF) || (wr_addr == EXT1_OFF) ||
                   (wr_addr == CTRL_OFF);
   wire wr_ctrl  = wr_fire && (wr_addr == CTRL_OFF) && wr_byte0;

   // write channel handshakes and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wbyte0_q  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_awaddr;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_wdata;
            wbyte0_q <= s_wstrb[0];
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
         // ready drops while a word is held or a response waits
         s_awready <= !aw_ok && !s_bvalid && !wr_fire && !s_awready;
         s_wready  <= !w_ok && !s_bvalid && !wr_fire && !s_wready;
      end
   end

   // control register; status and extension are read-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= wr_data[1:0];
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0;
         s_rresp   <= RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_word;
            s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
         s_arready <= !s_rvalid && !s_arready &&
                      !(s_arvalid && s_arready);
      end
   end

   // checks: capture moment, stability, decode, pin roles and write response
   a_capture_release: assert property (@(posedge aclk)
      $rose(aresetn) |=> cfg.captured && cfg.strap == $past(strap_pins))
      else $error("straps not captured one cycle after reset release");

   a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.captured && $past(cfg.captured) |-> $stable(cfg.strap))
      else $error("captured straps changed without reset");

   a_reset_released: assert property (@(posedge aclk)
      !aresetn |=> !strap_pins_oe_q && !cfg.captured)
      else $error("strap pins driven or captured during reset");

   a_bus_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.captured && {cfg.strap[LB_BIT], cfg.strap[ISA_BIT],
      cfg.strap[X2_BIT]} == 3'h6 |=> bus_mode_q == BUS_CPU_2X
      && clock_2x_q)
      else $error("cpu-direct double-clock combination misdecoded");

   a_reserved_bus: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.captured && (cfg.strap[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4})
      |=> bus_mode_q == BUS_RESERVED)
      else $error("reserved bus combination accepted as a mode");

   a_clock_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      config_valid_q |-> clock_2x_q == !cfg.strap[X2_BIT])
      else $error("clock rate flag does not follow strap");

   a_pin23_role: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_mode_q != BUS_CPU_2X |-> !cpu_reset_input_q)
      else $error("cpu reset seen outside double-clock mode");

   a_user_bit_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_arvalid && s_arready && s_araddr == EXT1_OFF |=>
      s_rvalid && s_rdata[EXT1_USER] == cfg.strap[USER_BIT])
      else $error("extension register bit 3 wrong");

   a_test_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.captured && cfg.clock_test |=> a24_oe_q && a25_oe_q
      && a24_out_q == $past(pixel_clock))
      else $error("clock test mode not driving A24/A25");

   a_rom_select: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.captured && is_isa && !cfg.clock_test |=> a24_oe_q
      && a24_out_q == !$past(ctrl_q[CTL_ROM]))
      else $error("rom select missing in legacy bus mode");

   a_pin_function: assert property (@(posedge aclk) disable iff (!aresetn)
      config_valid_q && !cfg.strap[PINF_BIT] |-> !pin54_oe_q)
      else $error("backlight driven while pins carry address");

   a_low_voltage: assert property (@(posedge aclk) disable iff (!aresetn)
      config_valid_q |-> low_voltage_q == !cfg.strap[LV_BIT]
      && osc_ext_q == !cfg.strap[OSC_BIT])
      else $error("voltage or oscillator flag wrong");

   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_bvalid && (s_bresp == RESP_OKAY) == $past(wr_known))
      else $error("write response missing or wrong code");

   // main scenarios
   c_cpu_2x: cover property (@(posedge aclk) bus_mode_q == BUS_CPU_2X);
   c_isa:    cover property (@(posedge aclk) bus_mode_q == BUS_ISA
                             && a24_oe_q);
   c_read:   cover property (@(posedge aclk) s_rvalid && s_rready);
   c_write:  cover property (@(posedge aclk) s_bvalid && s_bready);
endmodule

// ### sim/strap_board.sv
// board model: strap resistors on the display-memory address pins
// assumes the device releases the pins until its capture is done
`timescale 1ns/1ps
module strap_board
   import strap_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic [STRAP_W-1:0] pull_down,
   input  wire logic               bus_driven,
   output logic [STRAP_W-1:0]      strap_pins
);
   logic [STRAP_W-1:0] addr_q;
   logic [STRAP_W-1:0] fitted;

   // the reserved strap never gets a resistor fitted
   assign fitted = pull_down & ~(9'h001 << RSV_BIT);

   // address traffic once the memory side owns the pins, so a late
   // capture would pick up garbage instead of the straps
   always_ff @(posedge aclk) begin
      addr_q <= bus_driven ? ~{addr_q[7:0], addr_q[8]} : 9'h0A5;
   end

   // unfitted pins sit at the on-chip pull-up level
   assign strap_pins = bus_driven ? addr_q : ~fitted;
endmodule

// ### sim/strap_config_top_bench.sv
// self-checking bench for the strap capture top
// assumes the board model on the strap pins and a 10 mhz aclk
`timescale 1ns/1ps
module strap_config_top_bench;
   import strap_pkg::*;
   logic aclk, aresetn, oe, rr_n, pclk_in, mclk_in, p53, p54;
   logic rr_p, pclk_p, mclk_p, p53_p, p54_p;
   logic a24_o, a24_e, a25_o, a25_e, p54_o, p54_e, act, rdy, crst;
   logic c2x, osc, lv, cvalid, awready, wready, bvalid, arready, rvalid;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [1:0] hi_addr, bresp, rresp;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [STRAP_W-1:0] pull_down, strap_pins;
   bus_mode_t bmode;
   int fails, tests_run;

   strap_board board (.aclk(aclk), .pull_down(pull_down),
      .bus_driven(oe), .strap_pins(strap_pins));

   strap_config_top dut (.aclk(aclk), .aresetn(aresetn),
      .strap_pins(strap_pins), .strap_pins_oe_q(oe),
      .ready_return_n(rr_n), .pixel_clock(pclk_in),
      .memory_clock(mclk_in), .pin53_in(p53), .pin54_in(p54),
      .a24_out_q(a24_o), .a24_oe_q(a24_e), .a25_out_q(a25_o),
      .a25_oe_q(a25_e), .pin54_out_q(p54_o), .pin54_oe_q(p54_e),
      .activity_input_q(act), .high_address_q(hi_addr),
      .ready_return_q(rdy), .cpu_reset_input_q(crst),
      .bus_mode_q(bmode), .clock_2x_q(c2x), .osc_ext_q(osc),
      .low_voltage_q(lv), .config_valid_q(cvalid),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
      .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
      .s_rvalid(rvalid), .s_rready(rready));

   always #50 aclk = ~aclk;

   // random shared-pin levels; the _p copies are what the last edge saw
   always @(posedge aclk) begin
      {rr_p, pclk_p, mclk_p, p53_p, p54_p} <= {rr_n, pclk_in, mclk_in, p53, p54};
      {rr_n, pclk_in, mclk_in, p53, p54} <= 5'($urandom);
   end

   task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // reference decode: 0 vl, 1 cpu 2x, 2 legacy, 3 pci, 4 reserved
   function automatic int mode_of(input logic [8:0] s);
      case ({s[LB_BIT], s[ISA_BIT], s[X2_BIT]})
         3'h7: return 0;
         3'h6: return 1;
         3'h5: return 2;
         3'h3: return 3;
         default: return 4;
      endcase
   endfunction

   // master: ready sampled mid-cycle, handshake lands on the next edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      logic aw_t, w_t, got;
      int n;
      n = 0;
      got = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got && n < 50) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         got = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!got) fails++;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic ar_t, got;
      int n;
      n = 0;
      got = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got && n < 50) begin
         @(negedge aclk);
         ar_t = arvalid && arready;
         got = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!got) fails++;
   endtask

   // settled outputs against the strap word and control value
   task automatic check_pins(input logic [8:0] s, input logic [1:0] c);
      int m;
      m = mode_of(s);
      cmp_pin(32'(bmode), 32'(m));
      cmp_pin({c2x, osc, lv, cvalid}, {~s[X2_BIT], ~s[OSC_BIT], ~s[LV_BIT], 1'b1});
      if (!s[TEST_BIT]) cmp_pin({a24_e, a24_o, a25_e, a25_o}, {1'b1, pclk_p, 1'b1, mclk_p});
      else if (m == 2) cmp_pin({a24_e, a24_o, a25_e}, {1'b1, ~c[CTL_ROM], 1'b0});
      else cmp_pin({a24_e, a25_e}, 2'b00);
      if (s[PINF_BIT]) cmp_pin({p54_e, p54_o, act, hi_addr}, {1'b1, c[CTL_BKL], p53_p, 2'b00});
      else cmp_pin({p54_e, act, hi_addr}, {2'b00, p54_p, p53_p});
      if (m == 1) cmp_pin({crst, rdy}, {rr_p, 1'b0});
      else cmp_pin({crst, rdy}, {1'b0, ~rr_p});
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog: each configuration needs well under a hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      conclude();
   end

   initial begin
      logic [31:0] d, st;
      logic [1:0] r, c;
      logic [8:0] pd, s;
      int i;
      void'($urandom(55943));
      {aclk, aresetn, pull_down, awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {rr_n, pclk_in, mclk_in, p53, p54} = '0;
      wstrb = 4'hF;
      // first pass unstrapped, then every bus-select combination
      for (i = 0; i < 9; i++) begin
         pd = (i == 0) ? 9'h000 : {6'($urandom), 3'(i - 1)};
         // test mode on even passes only, so the legacy pass sees rom select
         if (i != 0) pd[TEST_BIT] = (i % 2 == 0);
         s = ~(pd & ~(9'h001 << RSV_BIT));
         @(posedge aclk);
         pull_down <= pd;
         aresetn <= 1'b0;
         repeat (5) @(posedge aclk);
         @(negedge aclk);
         cmp_pin({oe, cvalid}, 32'h0);
         @(posedge aclk);
         aresetn <= 1'b1;
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         check_pins(s, 2'b00);
         st = {17'h0, ~s[RSV_BIT], 1'b1, mode_of(s) == 4, 3'(mode_of(s)), s};
         axi_read(STATUS_OFF, d, r);
         cmp_bus({r, d}, {RESP_OKAY, st});
         axi_read(EXT1_OFF, d, r);
         cmp_bus({r, d}, {RESP_OKAY, 28'h0, s[USER_BIT], 3'h0});
         c = 2'($urandom);
         axi_write(CTRL_OFF, {30'h0, c}, r);
         cmp_bus({r, 32'h0}, {RESP_OKAY, 32'h0});
         axi_read(CTRL_OFF, d, r);
         cmp_bus({r, d}, {RESP_OKAY, 30'h0, c});
         @(negedge aclk);
         check_pins(s, c);
         axi_write(STATUS_OFF, 32'hFFFFFFFF, r);
         cmp_bus({r, 32'h0}, {RESP_OKAY, 32'h0});
         axi_read(STATUS_OFF, d, r);
         cmp_bus({r, d}, {RESP_OKAY, st});
         axi_read(8'h0C, d, r);
         cmp_bus({r, d}, {RESP_SLVERR, 32'h0});
         axi_write(8'h0C, 32'h0, r);
         cmp_bus({r, 32'h0}, {RESP_SLVERR, 32'h0});
      end
      conclude();
   end
endmodule
